// *** analog_input_diagnostic_record.sv ***
// diagnostic record of a four-channel analog input module
// assumes fault inputs synchronous to clk_i; read port is byte-wide
//
// Function
// - overflow of diagnostic buffer sets system bit 3
// - internal comms error sets bit 4; rest reserved
// - kind byte holds 7-bit type code, analog in
// - bits-per-channel descriptor reads constant 08h
// - channel-count descriptor reads constant 04h
// - group mask bit n flags error in channel n
// - channel byte bit 0 flags configuration error
// - channel byte bit 6 flags signal underrange
// - channel byte bit 7 flags signal overrange
// - four spare channel bytes carry no errors
// - timestamp captures ticker when event is recorded
// - microsecond ticker starts from zero at reset
// - ticker wraps to zero as 32-bit counter
// - channel lamp on range, config or wire-break
// - module lamp lit whenever any error is present
// - errors light lamps, all but wire-break are recorded, no interrupt
`timescale 1ns/1ps
module analog_input_diagnostic_record
  import aidiag_pkg::*;
#(
  parameter int NUM_CH = 4
)(
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // fault sources
  input  wire logic              diag_buf_ovf_i,
  input  wire logic              comm_err_i,
  input  wire logic [NUM_CH-1:0] cfg_err_i,
  input  wire logic [NUM_CH-1:0] under_range_i,
  input  wire logic [NUM_CH-1:0] over_range_i,
  input  wire logic [NUM_CH-1:0] wire_break_i,
  input  wire logic [NUM_CH-1:0] wire_break_en_i,
  // record read port
  input  wire logic              rd_en_i,
  input  wire logic [4:0]        rd_addr_i,
  output logic      [7:0]        rd_data_o,
  output logic                   rd_valid_o,
  // indicators
  output logic      [NUM_CH-1:0] channel_fault_lamp_o,
  output logic                   module_fault_lamp_o
);
  import aidiag_pkg::*;

  // ***********************************************************
  // helpers
  // ***********************************************************

  // one channel's error byte from its fault levels
  function automatic logic [7:0] chan_byte(input logic cfg,
                                           input logic under,
                                           input logic over);
    logic [7:0] b;
    b = BYTE_RESET;
    b[CH_CFG_ERR_BIT] = cfg;
    b[CH_UNDER_BIT]   = under;
    b[CH_OVER_BIT]    = over;
    return b;
  endfunction

  // ***********************************************************
  // microsecond ticker
  // ***********************************************************
  ticker_if tk ();

  us_ticker u_ticker (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tk      (tk)
  );

  // ***********************************************************
  // error state
  // ***********************************************************
  logic [7:0] sys_err_reg;
  logic [7:0] sys_err_next;
  logic [7:0] chan_err_reg  [NUM_CH];
  logic [7:0] chan_err_next [NUM_CH];
  logic [7:0] group_mask_reg;
  logic [7:0] group_mask_next;
  logic [31:0] stamp_reg;
  logic        new_event;

  // next record contents follow the fault levels
  always_comb
  begin
    sys_err_next = BYTE_RESET;
    sys_err_next[SYS_BUF_OVF_BIT]  = diag_buf_ovf_i;
    sys_err_next[SYS_COMM_ERR_BIT] = comm_err_i;
    group_mask_next = BYTE_RESET;
    for (int n = 0; n < NUM_CH; n++)
    begin
      chan_err_next[n] = chan_byte(cfg_err_i[n], under_range_i[n],
                                   over_range_i[n]);
      group_mask_next[n] = |chan_err_next[n];
    end
  end

  // a newly raised error bit is a diagnostic event
  always_comb
  begin
    new_event = |(sys_err_next & ~sys_err_reg);
    for (int n = 0; n < NUM_CH; n++)
      new_event = new_event | (|(chan_err_next[n] & ~chan_err_reg[n]));
  end

  // record the error state, no interrupt is raised
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sys_err_reg    <= BYTE_RESET;
      group_mask_reg <= BYTE_RESET;
      for (int n = 0; n < NUM_CH; n++)
        chan_err_reg[n] <= BYTE_RESET;
    end
    else
    begin
      sys_err_reg    <= sys_err_next;
      group_mask_reg <= group_mask_next;
      for (int n = 0; n < NUM_CH; n++)
        chan_err_reg[n] <= chan_err_next[n];
    end
  end

  // timestamp of the latest diagnostic event
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      stamp_reg <= STAMP_RESET;
    else if (new_event)
      stamp_reg <= tk.now;
  end

  // ***********************************************************
  // indicators
  // ***********************************************************

  // channel lamps: range, parameter or enabled wire-break fault
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      channel_fault_lamp_o <= '0;
    else
      channel_fault_lamp_o <= under_range_i | over_range_i | cfg_err_i
                              | (wire_break_i & wire_break_en_i);
  end

  // module lamp: any error in the module status
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      module_fault_lamp_o <= 1'b0;
    else
      module_fault_lamp_o <= (|sys_err_next) | (|group_mask_next)
                             | (|(wire_break_i & wire_break_en_i));
  end

  // ***********************************************************
  // record read port
  // ***********************************************************
  logic [7:0] rd_byte;
  logic [4:0] rel;

  // byte select; reserved and unmapped bytes read zero
  always_comb
  begin
    rd_byte = BYTE_RESET;
    rel     = 5'h00;
    if (rd_addr_i == OFF_SYS_ERR)
      rd_byte = sys_err_reg;
    else if (rd_addr_i == OFF_KIND)
      rd_byte = {1'b0, KIND_ANALOG_IN};
    else if (rd_addr_i == OFF_BITS)
      rd_byte = DIAG_BITS_VALUE;
    else if (rd_addr_i == OFF_COUNT)
      rd_byte = CHAN_COUNT_VALUE;
    else if (rd_addr_i == OFF_GROUP_MASK)
      rd_byte = group_mask_reg;
    else if (rd_addr_i >= OFF_CHAN_FIRST && rd_addr_i < OFF_SPARE_FIRST)
    begin
      rel = rd_addr_i - OFF_CHAN_FIRST;
      if (int'(rel) < NUM_CH)
        rd_byte = chan_err_reg[rel[1:0]];
    end
    else if (rd_addr_i >= OFF_SPARE_FIRST && rd_addr_i < OFF_STAMP_FIRST)
      rd_byte = BYTE_RESET;
    else if (rd_addr_i >= OFF_STAMP_FIRST && rd_addr_i <= OFF_LAST)
    begin
      rel = rd_addr_i - OFF_STAMP_FIRST;
      rd_byte = stamp_reg[8*rel[1:0] +: 8];
    end
  end

  // answer one cycle after the request
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_data_o  <= BYTE_RESET;
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i)
        rd_data_o <= rd_byte;
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  logic [7:0] gap_reg;

  // cycles since the last ticker pulse; saturated until the first one
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      gap_reg <= 8'hff;  // no period known right after reset
    else if (tk.tick)
      gap_reg <= 8'h00;
    else if (gap_reg != 8'hff)
      gap_reg <= gap_reg + 8'h01;
  end

  a_buf_ovf_bit: assert property (
    diag_buf_ovf_i |=> sys_err_reg[SYS_BUF_OVF_BIT])
    else $error("buffer overflow not recorded");

  a_comm_err_bit: assert property (
    $rose(comm_err_i) |=> sys_err_reg[SYS_COMM_ERR_BIT]
                          && (sys_err_reg[2:0] == 3'h0))
    else $error("comm error bit wrong");

  a_kind_read: assert property (
    rd_en_i && rd_addr_i == OFF_KIND |=> rd_valid_o && rd_data_o == 8'h71)
    else $error("channel kind wrong");

  a_bits_count_read: assert property (
    rd_en_i && rd_addr_i == OFF_BITS |=> rd_data_o == 8'h08)
    else $error("bits per channel wrong");

  a_chan_count_read: assert property (
    rd_en_i && rd_addr_i == OFF_COUNT |=> rd_data_o == 8'h04)
    else $error("channel count wrong");

  a_group_mask_map: assert property (
    group_mask_reg[7:4] == 4'h0
    && group_mask_reg[0] == (|chan_err_reg[0])
    && group_mask_reg[3] == (|chan_err_reg[3]))
    else $error("group mask does not match channels");

  a_cfg_err_bit: assert property (
    cfg_err_i[1] |=> chan_err_reg[1][CH_CFG_ERR_BIT]
                     && chan_err_reg[1][5:1] == 5'h00)
    else $error("config error bit wrong");

  a_under_bit: assert property (
    under_range_i[2] && !over_range_i[2] |=> chan_err_reg[2] [6]
                                          && !chan_err_reg[2][7])
    else $error("underrange bit wrong");

  a_over_bit: assert property (
    over_range_i[3] ##1 over_range_i[3] |=> group_mask_reg[3]
                                         && chan_err_reg[3][7])
    else $error("overrange bit wrong");

  a_spare_zero: assert property (
    rd_en_i && rd_addr_i >= OFF_SPARE_FIRST
    && rd_addr_i < OFF_STAMP_FIRST |=> rd_data_o == 8'h00)
    else $error("spare byte not zero");

  a_stamp_capture: assert property (
    new_event |=> stamp_reg == $past(tk.now))
    else $error("timestamp not captured");

  a_stamp_hold: assert property (
    !new_event |=> $stable(stamp_reg))
    else $error("timestamp changed without event");

  a_tick_period: assert property (
    tk.tick && $past(tk.tick, 1) == 1'b0 && gap_reg != 8'hff
    |-> gap_reg == 8'(TICK_CYCLES - 1))
    else $error("ticker period wrong");

  a_ticker_step: assert property (
    tk.tick |=> tk.now == $past(tk.now) + 32'h0000_0001)
    else $error("ticker step wrong");

  a_chan_lamp: assert property (
    wire_break_i[0] && wire_break_en_i[0] |=> channel_fault_lamp_o[0])
    else $error("wire break lamp off");

  a_module_lamp: assert property (
    (|group_mask_reg) || (|sys_err_reg) |-> module_fault_lamp_o)
    else $error("module lamp off with error");

  a_reserved_zero: assert property (
    rd_en_i && rd_addr_i == OFF_SYS_ERR |=> rd_data_o[7:5] == 3'h0
                                         && rd_data_o[2:0] == 3'h0)
    else $error("reserved bits not zero");

  a_sys_reserved: assert property (
    sys_err_reg[7:5] == 3'h0 && sys_err_reg[2:0] == 3'h0)
    else $error("system reserved bits set");

  a_chan_reserved: assert property (
    chan_err_reg[0][5:1] == 5'h00 && chan_err_reg[2][5:1] == 5'h00)
    else $error("channel reserved bits set");

  a_wb_not_recorded: assert property (
    wire_break_i[1] && !cfg_err_i[1] && !under_range_i[1]
    && !over_range_i[1] |=> chan_err_reg[1] == 8'h00)
    else $error("wire break entered the record");

  a_range_lamp: assert property (
    under_range_i[1] || over_range_i[1] |=> channel_fault_lamp_o[1])
    else $error("range lamp off");

  a_lamps_dark: assert property (
    !diag_buf_ovf_i && !comm_err_i && cfg_err_i == '0
    && under_range_i == '0 && over_range_i == '0
    && (wire_break_i & wire_break_en_i) == '0
    |=> !module_fault_lamp_o && channel_fault_lamp_o == '0)
    else $error("lamp lit without fault");

  a_group_follow: assert property (
    cfg_err_i[2] |=> group_mask_reg[2])
    else $error("group bit missing for channel error");

  a_stamp_read: assert property (
    rd_en_i && rd_addr_i == OFF_STAMP_FIRST
    |=> rd_data_o == $past(stamp_reg[7:0]))
    else $error("stamp byte read wrong");

  c_event_stamp: cover property (new_event ##1 stamp_reg != 32'h0);
  c_wire_break_lamp: cover property (wire_break_i[0] && wire_break_en_i[0]);
  c_stamp_read: cover property (rd_en_i && rd_addr_i == OFF_LAST);
  c_all_lamps: cover property (&channel_fault_lamp_o);
  c_two_ticks: cover property (tk.tick ##[1:80] tk.tick);

endmodule // analog_input_diagnostic_record

// *** aidiag_pkg.sv ***
// constants of the analog input diagnostic record
// assumes a 40 MHz system clock and a byte-wide record read port
package aidiag_pkg;

  // ***********************************************************
  // record byte indices
  // ***********************************************************
  localparam logic [4:0] OFF_SYS_ERR    = 5'h00;
  localparam logic [4:0] OFF_KIND       = 5'h01;
  localparam logic [4:0] OFF_BITS       = 5'h02;
  localparam logic [4:0] OFF_COUNT      = 5'h03;
  localparam logic [4:0] OFF_GROUP_MASK = 5'h04;
  localparam logic [4:0] OFF_CHAN_FIRST = 5'h05;
  localparam logic [4:0] OFF_SPARE_FIRST = 5'h09;
  localparam logic [4:0] OFF_STAMP_FIRST = 5'h0d;
  localparam logic [4:0] OFF_LAST       = 5'h10;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int SYS_BUF_OVF_BIT  = 3;
  localparam int SYS_COMM_ERR_BIT = 4;
  localparam int CH_CFG_ERR_BIT   = 0;
  localparam int CH_UNDER_BIT     = 6;
  localparam int CH_OVER_BIT      = 7;

  // ***********************************************************
  // constant record contents and reset values
  // ***********************************************************
  localparam logic [6:0] KIND_DIGITAL_IN  = 7'h70;
  localparam logic [6:0] KIND_ANALOG_IN   = 7'h71;
  localparam logic [6:0] KIND_DIGITAL_OUT = 7'h72;
  localparam logic [6:0] KIND_ANALOG_OUT  = 7'h73;
  localparam logic [6:0] KIND_ANALOG_IO   = 7'h74;
  localparam logic [6:0] KIND_COUNTER     = 7'h76;
  localparam logic [7:0] DIAG_BITS_VALUE  = 8'h08;
  localparam logic [7:0] CHAN_COUNT_VALUE = 8'h04;
  localparam logic [7:0] BYTE_RESET       = 8'h00;
  localparam logic [31:0] STAMP_RESET     = 32'h0000_0000;
  localparam logic [31:0] TICKER_RESET    = 32'h0000_0000;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_PERIOD_PS  = 25000;
  localparam int TICK_PERIOD_PS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_PS / CLK_PERIOD_PS;

endpackage

// *** ticker_if.sv ***
// carrier for the microsecond ticker between the ticker and the record
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface ticker_if;
  logic        tick;   // one-cycle pulse per microsecond
  logic [31:0] now;    // current microsecond count

  modport src (output tick, output now);
  modport snk (input tick, input now);
endinterface

// *** us_ticker.sv ***
// free-running microsecond ticker with a cycle divider
// assumes clk_i at the rate given in the package
`timescale 1ns/1ps
module us_ticker
  import aidiag_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
)(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  ticker_if.src     tk
);

  logic [7:0]  div_reg;
  logic [31:0] now_reg;
  logic        tick_reg;

  // divider: one enable pulse every DIV cycles
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      div_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end
    else if (div_reg == 8'(DIV - 1))
    begin
      div_reg  <= 8'h00;
      tick_reg <= 1'b1;
    end
    else
    begin
      div_reg  <= div_reg + 8'h01;
      tick_reg <= 1'b0;
    end
  end

  // count from zero, wrap naturally after all ones
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      now_reg <= TICKER_RESET;
    else if (tick_reg)
      now_reg <= now_reg + 32'h0000_0001;
  end

  assign tk.tick = tick_reg;
  assign tk.now  = now_reg;

endmodule // us_ticker

// *** record_reader.sv ***
// backplane-side reader model of the diagnostic record
// assumes a byte-wide read port answered one cycle after each request
`timescale 1ns/1ps
module record_reader
(
  input  wire logic       clk_i,
  output logic            rd_en_o,
  output logic [4:0]      rd_addr_o,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i
);
  // ***********************************************************
  // request lines and read task
  // ***********************************************************
  // idle request lines from time zero
  initial
  begin
    rd_en_o = 1'h0;
    rd_addr_o = 5'h00;
  end

  // reads n bytes back to back from a, first byte lowest
  task automatic rd(input logic [4:0] a, input int n,
                    output logic [31:0] d, output bit ok);
    ok = 1'b1;
    d = 32'h0;
    @(posedge clk_i);
    rd_en_o <= 1'h1;
    rd_addr_o <= a;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      if (i == n - 1)
      begin
        rd_en_o <= 1'h0;
        rd_addr_o <= ~a;  // released index does not linger
      end
      else
        rd_addr_o <= a + 5'(i + 1);
      #1;
      ok &= (rd_valid_i === 1'h1);  // answer one cycle after request
      d[8*i +: 8] = rd_data_i;
    end
  endtask
endmodule // record_reader

// *** analog_input_diagnostic_record_tb.sv ***
// self-checking bench of the analog input diagnostic record
// assumes record_reader as the backplane side, ticker divider of 40
`timescale 1ns/1ps
module analog_input_diagnostic_record_tb;
  import aidiag_pkg::*;

  typedef struct packed {
    logic ovf; logic comm; logic [3:0] cfg; logic [3:0] und;
    logic [3:0] ovr; logic [3:0] wb; logic [3:0] wbe;
    logic [3:0] lamp; logic mf; logic [3:0] mask;
  } row_t;

  logic       clk, rst_b, ovf, comm, rd_en, rd_valid, mf;
  logic [3:0] cfg, und, ovr, wb, wbe, lamp;
  logic [4:0] rd_addr;
  logic [7:0] rd_data, e;
  logic [31:0] d;
  int         mismatches, n_checks, cyc, k;
  bit         ok, found;

  // inputs, expected lamps, module lamp, group mask
  row_t rows [9] = '{
    '{1'h0,1'h0,4'h0,4'h0,4'h0,4'h0,4'h0,4'h0,1'h0,4'h0},
    '{1'h1,1'h0,4'h0,4'h0,4'h0,4'h0,4'h0,4'h0,1'h1,4'h0},
    '{1'h0,1'h1,4'h0,4'h0,4'h0,4'h0,4'h0,4'h0,1'h1,4'h0},
    '{1'h0,1'h0,4'h1,4'h0,4'h0,4'h0,4'h0,4'h1,1'h1,4'h1},
    '{1'h0,1'h0,4'h0,4'h2,4'h0,4'h0,4'h0,4'h2,1'h1,4'h2},
    '{1'h0,1'h0,4'h4,4'h0,4'h8,4'h0,4'h0,4'hc,1'h1,4'hc},
    '{1'h0,1'h0,4'h0,4'h0,4'h0,4'hf,4'h5,4'h5,1'h1,4'h0},
    '{1'h0,1'h0,4'h0,4'h0,4'h0,4'hf,4'h0,4'h0,1'h0,4'h0},
    '{1'h1,1'h1,4'hf,4'hf,4'hf,4'h0,4'hf,4'hf,1'h1,4'hf}
  };

  // ***********************************************************
  // clock, cycle count, design and reader
  // ***********************************************************
  initial clk = 1'h0;
  always #12.5 clk = ~clk;

  // edges since the last reset release
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) cyc <= 0;
    else cyc <= cyc + 1;

  analog_input_diagnostic_record dut (
    .clk_i(clk), .rst_b_i(rst_b), .diag_buf_ovf_i(ovf),
    .comm_err_i(comm), .cfg_err_i(cfg), .under_range_i(und),
    .over_range_i(ovr), .wire_break_i(wb), .wire_break_en_i(wbe),
    .rd_en_i(rd_en), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .channel_fault_lamp_o(lamp),
    .module_fault_lamp_o(mf));

  record_reader rdr (.clk_i(clk), .rd_en_o(rd_en), .rd_addr_o(rd_addr),
    .rd_data_i(rd_data), .rd_valid_i(rd_valid));

  // ***********************************************************
  // shared tasks
  // ***********************************************************
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      $display("Error at %0t: %s got %h expected %h", $time, what, got,
               exp);
      mismatches++;
    end
  endtask

  task automatic rb(input logic [4:0] a, input logic [7:0] x);
    logic [31:0] v;
    bit ack;
    rdr.rd(a, 1, v, ack);
    chk({31'h0, ack}, 32'h1, $sformatf("answer %h", a));
    chk({24'h0, v[7:0]}, {24'h0, x}, $sformatf("byte %h", a));
  endtask

  task automatic apply(input row_t r);
    @(posedge clk);
    ovf <= r.ovf;
    comm <= r.comm;
    cfg <= r.cfg;
    und <= r.und;
    ovr <= r.ovr;
    wb <= r.wb;
    wbe <= r.wbe;
  endtask

  task automatic reset_chk();
    chk({28'h0, lamp}, 32'h0, "lamps in reset");
    chk({31'h0, mf}, 32'h0, "module lamp in reset");
    chk({23'h0, rd_valid, rd_data}, 32'h0, "read port in reset");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial
  begin
    rst_b = 1'h0;
    {ovf, comm, cfg, und, ovr, wb, wbe} = '0;
    repeat (4) @(posedge clk);
    #1;
    reset_chk();
    @(posedge clk);
    rst_b <= 1'h1;
    // table of fault combinations
    for (int r = 0; r < 9; r++)
    begin
      apply(rows[r]);
      repeat (2) @(posedge clk);
      #1;
      chk({28'h0, lamp}, {28'h0, rows[r].lamp}, "lamps");
      chk({31'h0, mf}, {31'h0, rows[r].mf}, "module lamp");
      e = 8'h00;
      e[SYS_BUF_OVF_BIT] = rows[r].ovf;
      e[SYS_COMM_ERR_BIT] = rows[r].comm;
      rb(OFF_SYS_ERR, e);
      rb(OFF_GROUP_MASK, {4'h0, rows[r].mask});
      for (int c = 0; c < 4; c++)
      begin
        e = 8'h00;
        e[CH_CFG_ERR_BIT] = rows[r].cfg[c];
        e[CH_UNDER_BIT] = rows[r].und[c];
        e[CH_OVER_BIT] = rows[r].ovr[c];
        rb(OFF_CHAN_FIRST + 5'(c), e);
      end
    end
    // constants and reserved places with every fault but wire break present
    rb(OFF_KIND, {1'h0, KIND_ANALOG_IN});
    rb(OFF_BITS, DIAG_BITS_VALUE);
    rb(OFF_COUNT, CHAN_COUNT_VALUE);
    // answer stands one cycle, byte stays until the next read
    @(posedge clk);
    #1;
    chk({31'h0, rd_valid}, 32'h0, "answer one cycle only");
    chk({24'h0, rd_data}, {24'h0, CHAN_COUNT_VALUE}, "byte held");
    for (int a = int'(OFF_SPARE_FIRST); a < int'(OFF_STAMP_FIRST); a++)
      rb(5'(a), 8'h00);
    for (int a = int'(OFF_LAST) + 1; a < 32; a++)
      rb(5'(a), 8'h00);
    apply(rows[0]);
    // event mid-way between ticks, stamp read back to back
    found = 1'b0;
    for (int i = 0; i < 200 && !found; i++)
    begin
      @(posedge clk);
      #1;
      found = (cyc >= 100) && (cyc % TICK_CYCLES == TICK_CYCLES / 2);
    end
    k = cyc;
    chk({31'h0, found}, 32'h1, "tick phase");
    @(posedge clk);
    ovr <= 4'h8;
    repeat (3) @(posedge clk);
    rdr.rd(OFF_STAMP_FIRST, 4, d, ok);
    chk({31'h0, ok}, 32'h1, "stamp answer");
    chk(d, 32'(k / TICK_CYCLES), "event stamp");
    // second reset with a fault standing
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
    reset_chk();
    @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
    chk({28'h0, lamp}, 32'h8, "lamps after reset");
    rdr.rd(OFF_STAMP_FIRST, 4, d, ok);
    chk({31'h0, ok}, 32'h1, "stamp answer");
    chk(d, TICKER_RESET, "stamp from fresh ticker");
    finish_test();
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    $display("Error at %0t: run timed out", $time);
    mismatches++;
    finish_test();
  end
endmodule // analog_input_diagnostic_record_tb
